// file: core/vsd_consts.vh
// Constants for the VLIW syllable decoder: field positions and opcode codes
// What this block does
// - Top bit set marks last syllable
// - Two format bits classify the syllable
// - Bit 27 picks register or immediate form
// - Register form: first_source_gpr, second_source_gpr into dest
// - Immediate form: first_source_gpr, immediate into idest
// - Compare targets general or branch register
// - Load/store address first_source_gpr plus immediate
// - Short immediate 9 bits, extension 23
// - Syscall raises exception, alone in bundle
// - Immediate subtract: immediate minus first_source_gpr
// - Byte sign extension, sub-code 00000000
// - Half sign extension, sub-code 00000001
// - Half zero extension, sub-code 00000011
// - Xor with register or sign-extended immediate
// - Sync uses the load/store unit
// - Opcode 01110 immediate: single-operand sub-codes
`ifndef VSD_CONSTS_VH
`define VSD_CONSTS_VH

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VSD_STOP_BIT       31
`define VSD_FMT_HI         29
`define VSD_FMT_LO         28
`define VSD_IMMFORM_BIT    27
`define VSD_CMPSEL_BIT     26
`define VSD_CMPBR_BIT      25
`define VSD_OPC_HI         25
`define VSD_OPC_LO         21
`define VSD_SIMM_HI        20
`define VSD_SIMM_LO        12
`define VSD_DEST_HI        17
`define VSD_DEST_LO        12
`define VSD_REG_FORM_DEST_BRANCH_REG_HI       20
`define VSD_REG_FORM_DEST_BRANCH_REG_LO       18
`define VSD_IDEST_HI       11
`define VSD_IDEST_LO       6
`define VSD_IMM_FORM_DEST_BRANCH_REG_HI      8
`define VSD_IMM_FORM_DEST_BRANCH_REG_LO      6
`define VSD_FIRST_SOURCE_GPR_HI        5
`define VSD_FIRST_SOURCE_GPR_LO        0
`define VSD_EXT_HI         22
`define VSD_EXT_LO         0
`define VSD_SCNUM_HI       20
`define VSD_SCNUM_LO       0
`define VSD_SYSOPC_HI      27
`define VSD_SYSOPC_LO      21
`define VSD_MEMOPC_HI      27
`define VSD_MEMOPC_LO      23
`define VSD_IMMEXT_HI      27
`define VSD_IMMEXT_LO      24

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define VSD_FMT_INT        2'h0
`define VSD_FMT_IMM        2'h1
`define VSD_FMT_MEM        2'h2
`define VSD_FMT_CTL        2'h3
`define VSD_OP_SUB         5'h01
`define VSD_OP_XOR         5'h0D
`define VSD_OP_MONADIC     5'h0E
`define VSD_SUB_SXTB       9'h000
`define VSD_SUB_SXTH       9'h001
`define VSD_SUB_ZXTH       9'h003
`define VSD_SYS_SYSCALL    7'h7E
`define VSD_MEM_SYNC       5'h10
`define VSD_IMMEXT_OPC     4'h5
`define VSD_GPR_LAST       6'h3F
`define VSD_RESET_WORD     32'h0000_0000

`endif

// file: core/vsd_decoder.v
// VLIW syllable decoder: classifies syllables, decodes fields and evaluates simple operations
`timescale 1ns/10ps
`default_nettype none
`include "vsd_consts.vh"

module vsd_decoder #(
    parameter GPR_W  = 6,
    parameter DATA_W = 32
) (
    input  wire              CLK_I,
    input  wire              RST_B_I,
    input  wire              SYL_VALID_I,
    input  wire [31:0]       SYL_I,
    input  wire [DATA_W-1:0] FIRST_SOURCE_GPR_DATA_I,
    input  wire [DATA_W-1:0] SECOND_SOURCE_GPR_DATA_I,
    output reg               DEC_VALID_O,
    output reg               BUNDLE_END_O,
    output reg  [1:0]        FORMAT_O,
    output reg               IMM_FORM_O,
    output reg  [4:0]        OPCODE_O,
    output reg  [GPR_W-1:0]  FIRST_SOURCE_GPR_GPR_O,
    output reg  [GPR_W-1:0]  SECOND_SOURCE_GPR_GPR_O,
    output reg  [GPR_W-1:0]  DEST_GPR_O,
    output reg               DEST_GPR_WE_O,
    output reg  [2:0]        DEST_BR_O,
    output reg               DEST_BR_WE_O,
    output reg  [8:0]        SHORT_IMM_O,
    output reg  [22:0]       IMM_EXT_O,
    output reg               IMM_EXT_VALID_O,
    output reg               LSU_USE_O,
    output reg               IS_LOAD_O,
    output reg               IS_STORE_O,
    output reg               IS_SYNC_O,
    output reg               SYSCALL_O,
    output reg  [20:0]       SYSCALL_NUM_O,
    output reg               RESULT_VALID_O,
    output reg  [DATA_W-1:0] RESULT_O,
    output reg  [DATA_W-1:0] MEM_ADDR_O,
    output reg  [DATA_W-1:0] STORE_DATA_O,
    output reg               MUL_DEST_ERR_O,
    output reg               SYSCALL_BUNDLE_ERR_O,
    output reg               LSU_CONFLICT_O
);

    // ----------------------------------------------------------------
    // Field extraction
    // ----------------------------------------------------------------
    wire [1:0]       fmt       = SYL_I[`VSD_FMT_HI:`VSD_FMT_LO];
    wire             imm_form  = SYL_I[`VSD_IMMFORM_BIT];
    wire             cmp_sel   = SYL_I[`VSD_CMPSEL_BIT];
    wire             cmp_br    = SYL_I[`VSD_CMPBR_BIT];
    wire [4:0]       opc       = SYL_I[`VSD_OPC_HI:`VSD_OPC_LO];
    wire [8:0]       short_immediate_field = SYL_I[`VSD_SIMM_HI:`VSD_SIMM_LO];
    wire [5:0]       first_source_gpr      = SYL_I[`VSD_FIRST_SOURCE_GPR_HI:`VSD_FIRST_SOURCE_GPR_LO];
    wire [5:0]       second_source_gpr     = SYL_I[`VSD_IDEST_HI:`VSD_IDEST_LO];
    wire [5:0]       reg_form_dest         = SYL_I[`VSD_DEST_HI:`VSD_DEST_LO];
    wire [5:0]       imm_form_dest         = SYL_I[`VSD_IDEST_HI:`VSD_IDEST_LO];
    wire [2:0]       reg_form_dest_branch_reg = SYL_I[`VSD_REG_FORM_DEST_BRANCH_REG_HI:`VSD_REG_FORM_DEST_BRANCH_REG_LO];
    wire [2:0]       imm_form_dest_branch_reg = SYL_I[`VSD_IMM_FORM_DEST_BRANCH_REG_HI:`VSD_IMM_FORM_DEST_BRANCH_REG_LO];
    wire [6:0]       sys_opc   = SYL_I[`VSD_SYSOPC_HI:`VSD_SYSOPC_LO];
    wire [4:0]       mem_opc   = SYL_I[`VSD_MEMOPC_HI:`VSD_MEMOPC_LO];

    // Sign-extended short immediate, shared by arithmetic and addressing
    wire [DATA_W-1:0] simm_sx = {{(DATA_W-9){short_immediate_field[8]}}, short_immediate_field};

    // Multiply opcodes: 01111 and 10100..11111 without compare select; 01110/01111 and 11110/11111 with it
    function is_mul;
        input       sel;
        input [4:0] op;
        begin
            if (!sel)
                is_mul = (op == 5'h0F) || (op >= 5'h14);
            else
                is_mul = (op == 5'h0E) || (op == 5'h0F) || (op == 5'h1E) || (op == 5'h1F);
        end
    endfunction

    // ----------------------------------------------------------------
    // Combinational decode
    // ----------------------------------------------------------------
    reg              int_cls;
    reg              mul_op;
    reg              br_tgt;
    reg              gpr_we;
    reg [5:0]        dest_sel;
    reg              load_op;
    reg              store_op;
    reg              sync_op;
    reg              sc_op;
    reg              immx_op;
    reg              res_ok;
    reg [DATA_W-1:0] opnd2;
    reg [DATA_W-1:0] res;

    always @* begin
        int_cls  = (fmt == `VSD_FMT_INT);
        mul_op   = int_cls && is_mul(cmp_sel, opc);
        // Compare with bit 25 set targets a branch register
        br_tgt   = int_cls && cmp_sel && cmp_br && !is_mul(cmp_sel, opc);
        gpr_we   = int_cls && !br_tgt;
        // Register form writes bits 17:12, immediate form bits 11:6
        dest_sel = imm_form ? imm_form_dest : reg_form_dest;
        load_op  = (fmt == `VSD_FMT_MEM) && (mem_opc < 5'h0A);
        store_op = (fmt == `VSD_FMT_MEM) && (mem_opc >= 5'h0A) && (mem_opc <= 5'h0C);
        sync_op  = (fmt == `VSD_FMT_MEM) && (mem_opc == `VSD_MEM_SYNC);
        sc_op    = (fmt == `VSD_FMT_IMM) && (sys_opc == `VSD_SYS_SYSCALL);
        // Bits 29:28 are the class, so the extension opcode must be read below them
        immx_op  = (fmt == `VSD_FMT_IMM) && (SYL_I[`VSD_IMMEXT_HI:`VSD_IMMEXT_LO] == `VSD_IMMEXT_OPC);
        if (load_op) begin
            dest_sel = imm_form_dest;
            gpr_we   = 1'b1;
        end
        // Second operand: register or sign-extended immediate
        opnd2    = imm_form ? simm_sx : SECOND_SOURCE_GPR_DATA_I;
        res_ok   = 1'b0;
        res      = {DATA_W{1'b0}};
        if (int_cls && !cmp_sel) begin
            if (imm_form && opc == `VSD_OP_MONADIC) begin
                case (short_immediate_field)
                    `VSD_SUB_SXTB: begin
                        res    = {{(DATA_W-8){FIRST_SOURCE_GPR_DATA_I[7]}}, FIRST_SOURCE_GPR_DATA_I[7:0]};
                        res_ok = 1'b1;
                    end
                    `VSD_SUB_SXTH: begin
                        res    = {{(DATA_W-16){FIRST_SOURCE_GPR_DATA_I[15]}}, FIRST_SOURCE_GPR_DATA_I[15:0]};
                        res_ok = 1'b1;
                    end
                    `VSD_SUB_ZXTH: begin
                        res    = {{(DATA_W-16){1'b0}}, FIRST_SOURCE_GPR_DATA_I[15:0]};
                        res_ok = 1'b1;
                    end
                    default: begin
                        res    = {DATA_W{1'b0}};
                        res_ok = 1'b0;
                    end
                endcase
            end else if (opc == `VSD_OP_SUB) begin
                // Operand order is second minus first in both forms
                res    = opnd2 - FIRST_SOURCE_GPR_DATA_I;
                res_ok = 1'b1;
            end else if (opc == `VSD_OP_XOR) begin
                res    = FIRST_SOURCE_GPR_DATA_I ^ opnd2;
                res_ok = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bundle tracking for single-slot checks
    // ----------------------------------------------------------------
    // Flags whether a syllable, an LSU user and a syscall have been seen so far in the bundle in flight
    reg       in_bundle_reg;
    reg       in_bundle_next;
    reg       lsu_seen_reg;
    reg       lsu_seen_next;
    reg       sc_pend_reg;
    reg       sc_pend_next;

    always @* begin
        in_bundle_next = in_bundle_reg;
        lsu_seen_next  = lsu_seen_reg;
        sc_pend_next   = sc_pend_reg;
        if (SYL_VALID_I) begin
            if (SYL_I[`VSD_STOP_BIT]) begin
                in_bundle_next = 1'b0;
                lsu_seen_next  = 1'b0;
                sc_pend_next   = 1'b0;
            end else begin
                in_bundle_next = 1'b1;
                lsu_seen_next  = lsu_seen_reg | load_op | store_op | sync_op;
                sc_pend_next   = sc_pend_reg | sc_op;
            end
        end
    end

    // ----------------------------------------------------------------
    // Output registers, one cycle after the syllable is presented
    // ----------------------------------------------------------------
    always @(posedge CLK_I) begin
        if (!RST_B_I) begin
            in_bundle_reg        <= 1'b0;
            lsu_seen_reg         <= 1'b0;
            sc_pend_reg          <= 1'b0;
            DEC_VALID_O          <= 1'b0;
            BUNDLE_END_O         <= 1'b0;
            FORMAT_O             <= 2'h0;
            IMM_FORM_O           <= 1'b0;
            OPCODE_O             <= 5'h00;
            FIRST_SOURCE_GPR_GPR_O           <= {GPR_W{1'b0}};
            SECOND_SOURCE_GPR_GPR_O           <= {GPR_W{1'b0}};
            DEST_GPR_O           <= {GPR_W{1'b0}};
            DEST_GPR_WE_O        <= 1'b0;
            DEST_BR_O            <= 3'h0;
            DEST_BR_WE_O         <= 1'b0;
            SHORT_IMM_O          <= 9'h000;
            IMM_EXT_O            <= 23'h00_0000;
            IMM_EXT_VALID_O      <= 1'b0;
            LSU_USE_O            <= 1'b0;
            IS_LOAD_O            <= 1'b0;
            IS_STORE_O           <= 1'b0;
            IS_SYNC_O            <= 1'b0;
            SYSCALL_O            <= 1'b0;
            SYSCALL_NUM_O        <= 21'h00_0000;
            RESULT_VALID_O       <= 1'b0;
            RESULT_O             <= {DATA_W{1'b0}};
            MEM_ADDR_O           <= {DATA_W{1'b0}};
            STORE_DATA_O         <= {DATA_W{1'b0}};
            MUL_DEST_ERR_O       <= 1'b0;
            SYSCALL_BUNDLE_ERR_O <= 1'b0;
            LSU_CONFLICT_O       <= 1'b0;
        end else begin
            in_bundle_reg        <= in_bundle_next;
            lsu_seen_reg         <= lsu_seen_next;
            sc_pend_reg          <= sc_pend_next;
            DEC_VALID_O          <= SYL_VALID_I;
            BUNDLE_END_O         <= SYL_VALID_I & SYL_I[`VSD_STOP_BIT];
            FORMAT_O             <= fmt;
            IMM_FORM_O           <= imm_form;
            OPCODE_O             <= opc;
            FIRST_SOURCE_GPR_GPR_O           <= first_source_gpr[GPR_W-1:0];
            // Store data register shares the bits of the immediate-form destination
            SECOND_SOURCE_GPR_GPR_O           <= second_source_gpr[GPR_W-1:0];
            DEST_GPR_O           <= dest_sel[GPR_W-1:0];
            DEST_GPR_WE_O        <= SYL_VALID_I & gpr_we;
            DEST_BR_O            <= imm_form ? imm_form_dest_branch_reg : reg_form_dest_branch_reg;
            DEST_BR_WE_O         <= SYL_VALID_I & br_tgt;
            SHORT_IMM_O          <= short_immediate_field;
            IMM_EXT_O            <= SYL_I[`VSD_EXT_HI:`VSD_EXT_LO];
            IMM_EXT_VALID_O      <= SYL_VALID_I & immx_op;
            LSU_USE_O            <= SYL_VALID_I & (load_op | store_op | sync_op);
            IS_LOAD_O            <= SYL_VALID_I & load_op;
            IS_STORE_O           <= SYL_VALID_I & store_op;
            IS_SYNC_O            <= SYL_VALID_I & sync_op;
            SYSCALL_O            <= SYL_VALID_I & sc_op;
            SYSCALL_NUM_O        <= SYL_I[`VSD_SCNUM_HI:`VSD_SCNUM_LO];
            RESULT_VALID_O       <= SYL_VALID_I & res_ok;
            RESULT_O             <= res;
            // Effective address is first source plus sign-extended immediate
            MEM_ADDR_O           <= FIRST_SOURCE_GPR_DATA_I + simm_sx;
            STORE_DATA_O         <= SECOND_SOURCE_GPR_DATA_I;
            // Only flags producer mistakes; the result is still written as coded
            MUL_DEST_ERR_O       <= SYL_VALID_I & mul_op & (dest_sel == `VSD_GPR_LAST);
            SYSCALL_BUNDLE_ERR_O <= SYL_VALID_I & ((sc_op & (in_bundle_reg | ~SYL_I[`VSD_STOP_BIT]))
                                                   | (sc_pend_reg & ~sc_op));
            LSU_CONFLICT_O       <= SYL_VALID_I & lsu_seen_reg & (load_op | store_op | sync_op);
        end
    end

endmodule
`default_nettype wire

// file: test/vsd_decoder_props.sv
// Concurrent checks on the ports of the syllable decoder
`timescale 1ns/10ps
`default_nettype none
module vsd_decoder_props #(
    parameter GPR_W  = 6,
    parameter DATA_W = 32
) (
    input wire logic              CLK_I,
    input wire logic              RST_B_I,
    input wire logic              SYL_VALID_I,
    input wire logic [31:0]       SYL_I,
    input wire logic [DATA_W-1:0] FIRST_SOURCE_GPR_DATA_I,
    input wire logic [DATA_W-1:0] SECOND_SOURCE_GPR_DATA_I,
    input wire logic              DEC_VALID_O,
    input wire logic              BUNDLE_END_O,
    input wire logic [1:0]        FORMAT_O,
    input wire logic              IMM_FORM_O,
    input wire logic [GPR_W-1:0]  DEST_GPR_O,
    input wire logic              DEST_GPR_WE_O,
    input wire logic [8:0]        SHORT_IMM_O,
    input wire logic [22:0]       IMM_EXT_O,
    input wire logic              LSU_USE_O,
    input wire logic              IS_SYNC_O,
    input wire logic              SYSCALL_O,
    input wire logic [20:0]       SYSCALL_NUM_O,
    input wire logic              RESULT_VALID_O,
    input wire logic [DATA_W-1:0] RESULT_O,
    input wire logic [DATA_W-1:0] MEM_ADDR_O
);
    // ----------------------------------------------------------------
    // Assertions, all in the core clock domain
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    a_valid_latency: assert property (1'b1 |=> DEC_VALID_O == $past(SYL_VALID_I)) else $error("decode pulse off");
    a_stop_marks_end: assert property (SYL_VALID_I |=> BUNDLE_END_O == $past(SYL_I[31]))
        else $error("bundle end wrong");
    a_format_class: assert property (SYL_VALID_I |=> FORMAT_O == $past(SYL_I[29:28])
        && IMM_FORM_O == $past(SYL_I[27])) else $error("format wrong");
    a_imm_widths: assert property (SYL_VALID_I |=> SHORT_IMM_O == $past(SYL_I[20:12])
        && IMM_EXT_O == $past(SYL_I[22:0])) else $error("immediate field wrong");
    a_xor_reg_form: assert property (SYL_VALID_I && SYL_I[29:26] == 4'h0 && SYL_I[25:21] == 5'h0D
        |=> RESULT_VALID_O && RESULT_O == ($past(FIRST_SOURCE_GPR_DATA_I) ^ $past(SECOND_SOURCE_GPR_DATA_I))) else $error("xor wrong");
    a_sub_immediate: assert property (SYL_VALID_I && SYL_I[29:26] == 4'h2 && SYL_I[25:21] == 5'h01
        |=> RESULT_VALID_O && RESULT_O == {{(DATA_W-9){$past(SYL_I[20])}}, $past(SYL_I[20:12])}
        - $past(FIRST_SOURCE_GPR_DATA_I)) else $error("immediate subtract wrong");
    a_sync_lsu: assert property (SYL_VALID_I && SYL_I[29:28] == 2'h2 && SYL_I[27:23] == 5'h10
        |=> IS_SYNC_O && LSU_USE_O) else $error("sync lost");
    a_syscall_number: assert property (SYL_VALID_I && SYL_I[29:28] == 2'h1 && SYL_I[27:21] == 7'h7E
        |=> SYSCALL_O && SYSCALL_NUM_O == $past(SYL_I[20:0])) else $error("syscall wrong");
    a_mem_address: assert property (SYL_VALID_I && SYL_I[29:28] == 2'h2 && SYL_I[27:23] < 5'h0D
        |=> MEM_ADDR_O == $past(FIRST_SOURCE_GPR_DATA_I) + {{(DATA_W-9){$past(SYL_I[20])}}, $past(SYL_I[20:12])})
        else $error("address wrong");
    a_dest_form: assert property (SYL_VALID_I && SYL_I[29:28] == 2'h0 && !SYL_I[26]
        |=> DEST_GPR_WE_O && DEST_GPR_O == ($past(SYL_I[27]) ? $past(SYL_I[11:6]) : $past(SYL_I[17:12])))
        else $error("destination wrong");
    a_idle_quiet: assert property (!SYL_VALID_I |=> !RESULT_VALID_O && !SYSCALL_O) else $error("spurious pulse");
endmodule
bind vsd_decoder vsd_decoder_props #(.GPR_W(GPR_W), .DATA_W(DATA_W)) u_props (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .SYL_VALID_I(SYL_VALID_I), .SYL_I(SYL_I), .FIRST_SOURCE_GPR_DATA_I(FIRST_SOURCE_GPR_DATA_I),
    .SECOND_SOURCE_GPR_DATA_I(SECOND_SOURCE_GPR_DATA_I), .DEC_VALID_O(DEC_VALID_O), .BUNDLE_END_O(BUNDLE_END_O), .FORMAT_O(FORMAT_O),
    .IMM_FORM_O(IMM_FORM_O), .DEST_GPR_O(DEST_GPR_O), .DEST_GPR_WE_O(DEST_GPR_WE_O), .SHORT_IMM_O(SHORT_IMM_O),
    .IMM_EXT_O(IMM_EXT_O), .LSU_USE_O(LSU_USE_O), .IS_SYNC_O(IS_SYNC_O), .SYSCALL_O(SYSCALL_O),
    .SYSCALL_NUM_O(SYSCALL_NUM_O), .RESULT_VALID_O(RESULT_VALID_O), .RESULT_O(RESULT_O), .MEM_ADDR_O(MEM_ADDR_O));
`default_nettype wire

// file: test/vsd_regfile_model.sv
// Register file model that feeds source operands for the syllable in flight
`timescale 1ns/10ps
`default_nettype none
module vsd_regfile_model (
    input  wire logic        clk_i,
    input  wire logic        wr_en_i,
    input  wire logic [5:0]  wr_idx_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic [31:0] syl_i,
    output logic      [31:0] rd1_o,
    output logic      [31:0] rd2_o
);
    logic [31:0] regs_reg [0:63];
    // Loaded by the bench before traffic; reads are same-cycle as the decoder expects
    always @(posedge clk_i) begin
        if (wr_en_i) regs_reg[wr_idx_i] <= wr_data_i;
    end
    assign rd1_o = regs_reg[syl_i[5:0]];
    assign rd2_o = regs_reg[syl_i[11:6]];
endmodule
`default_nettype wire

// file: test/test_vsd_decoder.sv
// Self-checking bench for the syllable decoder with a reference model
`timescale 1ns/10ps
`default_nettype none
`include "vsd_consts.vh"
module test_vsd_decoder;
    logic        clk, rst_b, syl_valid, rf_we, dec_valid, bundle_end, imm_form, dest_we, br_we, ext_valid;
    logic        lsu_use, is_load, is_store, is_sync, sys_o, res_valid, mul_err, sys_err, lsu_conf;
    logic [1:0]  fmt;
    logic [2:0]  dbr;
    logic [4:0]  opc;
    logic [5:0]  rf_widx, s1g, s2g, dg;
    logic [8:0]  simm;
    logic [20:0] snum;
    logic [22:0] iext;
    logic [31:0] syl, rf_wdata, rs1, rs2, res, maddr, sdata, rnd;
    logic [31:0] rf [0:63];
    logic [31:0] q_syl [$];
    logic [2:0]  q_err [$];
    logic        open_b, lsu_seen, sys_pend;
    int          n_mismatch, check_count;
    vsd_regfile_model u_rf (.clk_i(clk), .wr_en_i(rf_we), .wr_idx_i(rf_widx), .wr_data_i(rf_wdata), .syl_i(syl),
        .rd1_o(rs1), .rd2_o(rs2));
    vsd_decoder #(.GPR_W(6), .DATA_W(32)) DUT (.CLK_I(clk), .RST_B_I(rst_b), .SYL_VALID_I(syl_valid), .SYL_I(syl),
        .FIRST_SOURCE_GPR_DATA_I(rs1), .SECOND_SOURCE_GPR_DATA_I(rs2), .DEC_VALID_O(dec_valid), .BUNDLE_END_O(bundle_end), .FORMAT_O(fmt),
        .IMM_FORM_O(imm_form), .OPCODE_O(opc), .FIRST_SOURCE_GPR_GPR_O(s1g), .SECOND_SOURCE_GPR_GPR_O(s2g), .DEST_GPR_O(dg),
        .DEST_GPR_WE_O(dest_we), .DEST_BR_O(dbr), .DEST_BR_WE_O(br_we), .SHORT_IMM_O(simm), .IMM_EXT_O(iext),
        .IMM_EXT_VALID_O(ext_valid), .LSU_USE_O(lsu_use), .IS_LOAD_O(is_load), .IS_STORE_O(is_store),
        .IS_SYNC_O(is_sync), .SYSCALL_O(sys_o), .SYSCALL_NUM_O(snum), .RESULT_VALID_O(res_valid), .RESULT_O(res),
        .MEM_ADDR_O(maddr), .STORE_DATA_O(sdata), .MUL_DEST_ERR_O(mul_err), .SYSCALL_BUNDLE_ERR_O(sys_err),
        .LSU_CONFLICT_O(lsu_conf));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // Syllable templates; reserved bits stay zero and every one closes its bundle
    function automatic logic [31:0] make(input int k, input logic [31:0] r);
        case (k)
            0: make = {6'h20, 5'h0D, 3'h0, r[17:0]};
            1: make = {6'h22, 5'h0D, r[20:0]};
            2: make = {6'h20, 5'h01, 3'h0, r[17:0]};
            3: make = {6'h22, 5'h01, r[20:0]};
            4: make = {6'h22, 5'h0E, 9'h000, r[11:0]};
            5: make = {6'h22, 5'h0E, 9'h001, r[11:0]};
            6: make = {6'h22, 5'h0E, 9'h003, r[11:0]};
            7: make = {7'h43, 4'h0, r[20:18], 6'h00, r[11:0]};
            8: make = {7'h46, 4'h1, r[20:0]};
            9: make = {7'h47, 4'h2, r[20:12], 3'h0, r[8:0]};
            10: make = {4'hA, 5'h00, 2'h0, r[20:0]};
            11: make = {4'hA, 5'h0A, 2'h0, r[20:0]};
            12: make = {4'hA, `VSD_MEM_SYNC, 23'h0};
            14: make = {4'h9, 5'h0A, r[22:0]};
            default: make = {4'h9, `VSD_SYS_SYSCALL, r[20:0]};
        endcase
    endfunction
    task automatic check(input logic ok, input string what);
        begin
            check_count++;
            if (ok !== 1'b1) begin
                n_mismatch++;
                $display("unexpected at %0t: %s", $time, what);
            end
        end
    endtask
    // Reference model: bundle flags worked out at issue, values at compare time
    task automatic issue(input logic [31:0] s);
        logic lsu, sc, mul;
        begin
            lsu = s[29:28] == 2'h2;
            sc = s[29:28] == 2'h1 && s[27:21] == `VSD_SYS_SYSCALL;
            // Multiplies: 01111 and 10100 up without compare select, x111x with it
            mul = s[29:28] == 2'h0 && (s[26] ? s[24:22] == 3'h7 : (s[25:21] == 5'h0F || s[25:21] >= 5'h14))
                  && (s[27] ? s[11:6] : s[17:12]) == 6'h3F;
            q_syl.push_back(s);
            q_err.push_back({mul, (sc && (open_b || !s[31])) || (open_b && sys_pend), lsu && lsu_seen});
            lsu_seen = s[31] ? 1'b0 : lsu_seen | lsu;
            sys_pend = s[31] ? 1'b0 : sys_pend | sc;
            open_b = !s[31];
            @(posedge clk);
            syl_valid <= 1'b1;
            syl <= s;
        end
    endtask
    task automatic verify(input logic [31:0] s, input logic [2:0] e);
        logic [31:0] a, b, sx, ex;
        logic        rv, mon, br;
        begin
            a = rf[s[5:0]];
            b = rf[s[11:6]];
            sx = {{23{s[20]}}, s[20:12]};
            rv = s[29:28] == 2'h0 && !s[26];
            mon = rv && s[27] && s[25:21] == `VSD_OP_MONADIC;
            // Opcodes 1 1110 and 1 1111 under compare select are multiplies, not branch compares
            br = s[29:28] == 2'h0 && s[26] && s[25] && s[24:21] < 4'hE;
            ex = 32'h0;
            if (rv && s[25:21] == `VSD_OP_SUB) ex = s[27] ? sx - a : b - a;
            else if (rv && s[25:21] == `VSD_OP_XOR) ex = a ^ (s[27] ? sx : b);
            else if (mon && s[20:12] == `VSD_SUB_SXTB) ex = {{24{a[7]}}, a[7:0]};
            else if (mon && s[20:12] == `VSD_SUB_SXTH) ex = {{16{a[15]}}, a[15:0]};
            else if (mon && s[20:12] == `VSD_SUB_ZXTH) ex = {16'h0, a[15:0]};
            else rv = 1'b0;
            check(bundle_end === s[31], "stop bit");
            check(fmt === s[29:28] && imm_form === s[27] && opc === s[25:21], "class");
            check(s1g === s[5:0] && simm === s[20:12] && iext === s[22:0], "fields");
            check(res_valid === rv && (!rv || res === ex), "result");
            if (s[29:28] == 2'h0) check(br_we === br, "branch target enable");
            if (s[29:28] == 2'h0 && !br)
                check(dest_we === 1'b1 && dg === (s[27] ? s[11:6] : s[17:12]), "dest");
            if (br) check(dbr === (s[27] ? s[8:6] : s[20:18]), "branch target");
            if (s[29:28] == 2'h2 && s[27:23] < 5'h0A)
                check(is_load === 1'b1 && dg === s[11:6] && maddr === a + sx, "load");
            if (s[29:28] == 2'h2 && s[27:23] == 5'h0A)
                check(is_store === 1'b1 && s2g === s[11:6] && sdata === b && maddr === a + sx, "store");
            if (s[29:28] == 2'h2 && s[27:23] == `VSD_MEM_SYNC)
                check(is_sync === 1'b1 && lsu_use === 1'b1, "sync");
            check(sys_o === (s[29:28] == 2'h1 && s[27:21] == `VSD_SYS_SYSCALL)
                  && (!sys_o || snum === s[20:0]), "syscall");
            check(ext_valid === (s[29:28] == 2'h1 && s[27:24] == 4'h5), "extension");
            check({mul_err, sys_err, lsu_conf} === e, "bundle flags");
        end
    endtask
    task automatic finish_test;
        begin
            $display("mismatches %0d, comparisons %0d", n_mismatch, check_count);
            if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Results are compared half a cycle after they land, in issue order
    always @(negedge clk) begin
        if (rst_b === 1'b1 && dec_valid !== 1'b0) begin
            if (q_syl.size() == 0) check(1'b0, "decode pulse without syllable");
            else verify(q_syl.pop_front(), q_err.pop_front());
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'b0; syl_valid = 1'b0; syl = 32'h0; rf_we = 1'b0; rf_widx = 6'h00; rf_wdata = 32'h0;
        rnd = 32'h21; n_mismatch = 0; check_count = 0; open_b = 1'b0; lsu_seen = 1'b0; sys_pend = 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        check(dec_valid === 1'b0 && bundle_end === 1'b0 && res === 32'h0, "reset state");
        for (int i = 0; i < 64; i++) begin
            rnd = xs(rnd);
            rf[i] = rnd;
            @(posedge clk);
            rf_we <= 1'b1; rf_widx <= i[5:0]; rf_wdata <= rnd;
        end
        @(posedge clk);
        rf_we <= 1'b0;
        for (int k = 0; k < 15; k++) issue(make(k, xs(rnd + k)));
        for (int n = 0; n < 300; n++) begin
            rnd = xs(rnd);
            issue(make(rnd[31:28] % 15, xs(rnd)));
        end
        issue(make(10, rnd) & 32'h7FFF_FFFF); issue(make(11, rnd));
        issue(make(12, rnd) & 32'h7FFF_FFFF); issue(make(10, xs(rnd)));
        issue(make(0, rnd) & 32'h7FFF_FFFF); issue(make(13, rnd));
        issue({6'h20, 5'h15, 3'h0, 6'h3F, rnd[11:0]}); issue({6'h22, 5'h15, rnd[20:12], 6'h3F, rnd[5:0]});
        issue({6'h22, 5'h15, rnd[20:12], 6'h3E, rnd[5:0]});
        issue({6'h23, 5'h1E, rnd[20:12], 6'h3F, rnd[5:0]});
        @(posedge clk);
        syl_valid <= 1'b0;
        for (int w = 0; w < 10 && q_syl.size() != 0; w++) @(posedge clk);
        if (q_syl.size() != 0) check(1'b0, "results missing");
        finish_test();
    end
endmodule
`default_nettype wire
